// File: axis_port_defs.vh
`ifndef AXIS_PORT_DEFS_VH
`define AXIS_PORT_DEFS_VH

// Host bus mode strap values
`define MODE_BUS8             1'b0
`define MODE_BUS16            1'b1

// 8-bit mode locations, address bits 2..0
`define LOC8_CMD_CODE         3'h0
`define LOC8_AXIS_SEL         3'h1
`define LOC8_PORT             3'h2
`define LOC8_INVALID          3'h3
`define LOC8_BUF_BYTE0        3'h4
`define LOC8_BUF_BYTE1        3'h5
`define LOC8_BUF_BYTE2        3'h6
`define LOC8_BUF_BYTE3        3'h7

// 16-bit mode locations, address bits 2..1
`define LOC16_CMD_WORD        2'h0
`define LOC16_PORT            2'h1
`define LOC16_BUF_LOW         2'h2
`define LOC16_BUF_HIGH        2'h3

// Command word fields
`define CMDW_CODE_MSB         7
`define CMDW_CODE_LSB         0
`define CMDW_SEL_MSB          11
`define CMDW_SEL_LSB          8

// Command codes
`define CMD_SOFT_RESET        8'h04
`define CMD_CLASS_REG_WRITE   2'h2
`define CMD_CLASS_REG_READ    2'h3

// Reset values
`define RST_CMD_CODE          8'h00
`define RST_AXIS_SEL          4'h0
`define RST_PORT_OUT          8'h00
`define RST_IO_BUFFER         32'h0000_0000
`define RST_DATA_OUT          16'h0000

// Internal register index width per axis
`define REG_INDEX_W           6

`endif

// File: pin_sync.v
`timescale 1ns/10ps
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Data
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_reg;

    // Two-stage synchroniser
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RESET_VALUE;
            dout     <= RESET_VALUE;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end

endmodule

// File: axis_reg_mem.v
`timescale 1ns/10ps
`include "axis_port_defs.vh"
module axis_reg_mem (
    // Clock
    input  wire                       clk,
    // Write port
    input  wire                       wr_en,
    input  wire [`REG_INDEX_W+1:0]    wr_addr,
    input  wire [31:0]                wr_data,
    // Read port
    input  wire [`REG_INDEX_W+1:0]    rd_addr,
    output reg  [31:0]                rd_data
);

    localparam DEPTH = 4 << `REG_INDEX_W;

    reg [31:0] mem [0:DEPTH-1];

    // Registered read, returns the old word when the same address is written
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule

// File: axis_cpu_port.v
`timescale 1ns/10ps
`include "axis_port_defs.vh"
module axis_cpu_port (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rst_n,
    // Bus mode strap
    input  wire        bus_mode,
    // Host bus pins
    input  wire        cs_n,
    input  wire        rd_n,
    input  wire        wr_n,
    input  wire [4:0]  addr,
    input  wire [15:0] data_in,
    output reg  [15:0] data_out,
    output reg         data_oe_n,
    output reg         busy,
    // Axis status from core
    input  wire [63:0] main_status,
    input  wire [31:0] sub_status,
    input  wire [31:0] port_dir,
    // General purpose terminals
    input  wire [31:0] general_purpose_terminals,
    output reg  [31:0] port_out_bits,
    // Command dispatch to axes
    output reg  [3:0]  cmd_strobe,
    output reg  [7:0]  cmd_code_out
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_WRITE = 2'h1;
    localparam ST_READ  = 2'h2;
    localparam ST_RCAP  = 2'h3;

    // Reset release
    reg rst_meta_reg;
    reg rst_sync_reg;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire soft_reset_command_n = rst_sync_reg;

    // Pin synchronisers
    wire [24:0] pins_s;
    pin_sync #(
        .WIDTH       (25),
        .RESET_VALUE ({9'h000, 16'h0000})
    ) u_bus_sync (
        .clk   (ref_clk),
        .rst_n (soft_reset_command_n),
        .din   ({~cs_n, ~rd_n, ~wr_n, bus_mode, addr[4:0], data_in}),
        .dout  (pins_s)
    );

    wire [31:0] terminals_s;
    pin_sync #(
        .WIDTH       (32),
        .RESET_VALUE (32'h0000_0000)
    ) u_term_sync (
        .clk   (ref_clk),
        .rst_n (soft_reset_command_n),
        .din   (general_purpose_terminals),
        .dout  (terminals_s)
    );

    wire        cs_act   = pins_s[24];
    wire        rd_act   = pins_s[23];
    wire        wr_act   = pins_s[22];
    wire        mode_s   = pins_s[21];
    wire [4:0]  addr_s   = pins_s[20:16];
    wire [15:0] data_s   = pins_s[15:0];

    // Previous sample, used at strobe end
    reg         wr_prev_reg;
    reg         cs_prev_reg;
    reg [4:0]   addr_prev_reg;
    reg [15:0]  data_prev_reg;
    always @(posedge ref_clk or negedge soft_reset_command_n) begin
        if (!soft_reset_command_n) begin
            wr_prev_reg   <= 1'b0;
            cs_prev_reg   <= 1'b0;
            addr_prev_reg <= 5'h00;
            data_prev_reg <= 16'h0000;
        end else begin
            wr_prev_reg   <= wr_act;
            cs_prev_reg   <= cs_act;
            addr_prev_reg <= addr_s;
            data_prev_reg <= data_s;
        end
    end

    wire       wr_done  = wr_prev_reg & cs_prev_reg & ~(wr_act & cs_act);
    wire [1:0] wr_axis  = addr_prev_reg[4:3];

    // Host registers
    reg [7:0]  cmd_code_reg;
    reg [3:0]  axis_sel_reg;
    reg [31:0] io_buffer [0:3];

    // FSM registers
    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [3:0]  mask_reg;
    reg [1:0]  idx_reg;
    reg [`REG_INDEX_W-1:0] regnum_reg;

    // Write decode
    reg        dec_cmd;
    reg        dec_sel;
    reg        dec_port;
    reg [3:0]  dec_be;
    reg [31:0] dec_bdata;
    reg [7:0]  dec_code;
    reg [3:0]  dec_selbits;
    reg [7:0]  dec_port_data;
    always @* begin
        dec_cmd       = 1'b0;
        dec_sel       = 1'b0;
        dec_port      = 1'b0;
        dec_be        = 4'h0;
        dec_bdata     = {2{data_prev_reg}};
        dec_code      = data_prev_reg[7:0];
        dec_selbits   = axis_sel_reg;
        dec_port_data = data_prev_reg[7:0];
        if (wr_done) begin
            if (mode_s == `MODE_BUS8) begin
                dec_bdata = {4{data_prev_reg[7:0]}};
                case (addr_prev_reg[2:0])
                    `LOC8_CMD_CODE:  dec_cmd  = 1'b1;
                    `LOC8_AXIS_SEL:  dec_sel  = 1'b1;
                    `LOC8_PORT:      dec_port = 1'b1;
                    `LOC8_INVALID:   dec_cmd  = 1'b0;
                    `LOC8_BUF_BYTE0: dec_be   = 4'h1;
                    `LOC8_BUF_BYTE1: dec_be   = 4'h2;
                    `LOC8_BUF_BYTE2: dec_be   = 4'h4;
                    `LOC8_BUF_BYTE3: dec_be   = 4'h8;
                    default:         dec_be   = 4'h0;
                endcase
            end else begin
                case (addr_prev_reg[2:1])
                    `LOC16_CMD_WORD: begin
                        dec_cmd     = 1'b1;
                        dec_code    = data_prev_reg[`CMDW_CODE_MSB:`CMDW_CODE_LSB];
                        dec_selbits = data_prev_reg[`CMDW_SEL_MSB:`CMDW_SEL_LSB];
                    end
                    `LOC16_PORT: begin
                        dec_port = 1'b1;
                    end
                    `LOC16_BUF_LOW: begin
                        dec_be = 4'h3;
                    end
                    `LOC16_BUF_HIGH: begin
                        dec_be = 4'hc;
                    end
                    default: begin
                        dec_be = 4'h0;
                    end
                endcase
            end
        end
    end

    // Target axes of a command
    reg [3:0] targets;
    always @* begin
        if (dec_code == `CMD_SOFT_RESET) begin
            targets = 4'hf;
        end else if (dec_selbits == 4'h0) begin
            targets = 4'h1 << wr_axis;
        end else begin
            targets = dec_selbits;
        end
    end

    wire is_reg_wr = (dec_code[7:6] == `CMD_CLASS_REG_WRITE);
    wire is_reg_rd = (dec_code[7:6] == `CMD_CLASS_REG_READ);
    wire fsm_start = dec_cmd & (state_reg == ST_IDLE) & (is_reg_wr | is_reg_rd);

    // Command and selection registers, dispatch
    always @(posedge ref_clk or negedge soft_reset_command_n) begin
        if (!soft_reset_command_n) begin
            cmd_code_reg <= `RST_CMD_CODE;
            axis_sel_reg <= `RST_AXIS_SEL;
            cmd_strobe   <= 4'h0;
            cmd_code_out <= `RST_CMD_CODE;
        end else begin
            cmd_strobe <= 4'h0;
            if (dec_sel) begin
                axis_sel_reg <= data_prev_reg[3:0];
            end
            if (dec_cmd) begin
                cmd_code_reg <= dec_code;
                cmd_code_out <= dec_code;
                cmd_strobe   <= targets;
            end
        end
    end

    // Register transfer sequencer
    wire idx_last = (idx_reg == 2'h3);
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (fsm_start) begin
                    state_next = is_reg_wr ? ST_WRITE : ST_READ;
                end
            end
            ST_WRITE: begin
                if (idx_last) begin
                    state_next = ST_IDLE;
                end
            end
            ST_READ: begin
                if (mask_reg[idx_reg]) begin
                    state_next = ST_RCAP;
                end else if (idx_last) begin
                    state_next = ST_IDLE;
                end
            end
            ST_RCAP: begin
                state_next = idx_last ? ST_IDLE : ST_READ;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge soft_reset_command_n) begin
        if (!soft_reset_command_n) begin
            state_reg  <= ST_IDLE;
            mask_reg   <= 4'h0;
            idx_reg    <= 2'h0;
            regnum_reg <= {`REG_INDEX_W{1'b0}};
            busy       <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy      <= (state_next != ST_IDLE);
            if (fsm_start) begin
                mask_reg   <= targets;
                idx_reg    <= 2'h0;
                regnum_reg <= dec_code[`REG_INDEX_W-1:0];
            end else if (state_reg == ST_WRITE || state_reg == ST_RCAP ||
                         (state_reg == ST_READ && !mask_reg[idx_reg])) begin
                idx_reg <= idx_reg + 2'h1;
            end
        end
    end

    // Per-axis register store
    wire        mem_we = (state_reg == ST_WRITE) & mask_reg[idx_reg];
    wire [31:0] mem_rd_data;
    axis_reg_mem u_mem (
        .clk     (ref_clk),
        .wr_en   (mem_we),
        .wr_addr ({idx_reg, regnum_reg}),
        .wr_data (io_buffer[idx_reg]),
        .rd_addr ({idx_reg, regnum_reg}),
        .rd_data (mem_rd_data)
    );

    // Per-axis buffers and output ports
    wire [31:0] be_mask = {{8{dec_be[3]}}, {8{dec_be[2]}}, {8{dec_be[1]}}, {8{dec_be[0]}}};
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_axis
            wire host_hit = (wr_axis == g);
            always @(posedge ref_clk or negedge soft_reset_command_n) begin
                if (!soft_reset_command_n) begin
                    io_buffer[g]          <= `RST_IO_BUFFER;
                    port_out_bits[g*8+:8] <= `RST_PORT_OUT;
                end else begin
                    if (state_reg == ST_RCAP && idx_reg == g) begin
                        io_buffer[g] <= mem_rd_data;
                    end else if (host_hit) begin
                        io_buffer[g] <= (io_buffer[g] & ~be_mask) | (dec_bdata & be_mask);
                    end
                    if (host_hit && dec_port) begin
                        port_out_bits[g*8+:8] <= (port_out_bits[g*8+:8] & ~port_dir[g*8+:8]) |
                                                 (dec_port_data & port_dir[g*8+:8]);
                    end
                end
            end
        end
    endgenerate

    // Read path
    wire [1:0]  rd_axis  = addr_s[4:3];
    wire [31:0] rd_buf   = io_buffer[rd_axis];
    wire [15:0] rd_mst   = main_status[rd_axis*16+:16];
    wire [7:0]  rd_sst   = sub_status[rd_axis*8+:8];
    wire [7:0]  rd_port  = terminals_s[rd_axis*8+:8];
    reg  [15:0] rd_mux;
    always @* begin
        rd_mux = 16'h0000;
        if (mode_s == `MODE_BUS8) begin
            case (addr_s[2:0])
                `LOC8_CMD_CODE:  rd_mux = {8'h00, rd_mst[7:0]};
                `LOC8_AXIS_SEL:  rd_mux = {8'h00, rd_mst[15:8]};
                `LOC8_PORT:      rd_mux = {8'h00, rd_port};
                `LOC8_INVALID:   rd_mux = {8'h00, rd_sst};
                `LOC8_BUF_BYTE0: rd_mux = {8'h00, rd_buf[7:0]};
                `LOC8_BUF_BYTE1: rd_mux = {8'h00, rd_buf[15:8]};
                `LOC8_BUF_BYTE2: rd_mux = {8'h00, rd_buf[23:16]};
                `LOC8_BUF_BYTE3: rd_mux = {8'h00, rd_buf[31:24]};
                default:         rd_mux = 16'h0000;
            endcase
        end else begin
            case (addr_s[2:1])
                `LOC16_CMD_WORD: rd_mux = rd_mst;
                `LOC16_PORT:     rd_mux = {rd_sst, rd_port};
                `LOC16_BUF_LOW:  rd_mux = rd_buf[15:0];
                `LOC16_BUF_HIGH: rd_mux = rd_buf[31:16];
                default:         rd_mux = 16'h0000;
            endcase
        end
    end

    // Data bus drive while read strobe active
    always @(posedge ref_clk or negedge soft_reset_command_n) begin
        if (!soft_reset_command_n) begin
            data_out  <= `RST_DATA_OUT;
            data_oe_n <= 1'b1;
        end else begin
            data_oe_n <= ~(cs_act & rd_act);
            if (cs_act & rd_act) begin
                data_out <= rd_mux;
            end
        end
    end

endmodule

// File: axis_cpu_port_checker.sv
`timescale 1ns/10ps
`include "axis_port_defs.vh"
module axis_cpu_port_checker (
    // Clock and reset
    input wire        ref_clk,
    input wire        rst_n,
    // Host bus
    input wire        bus_mode,
    input wire        cs_n,
    input wire        rd_n,
    input wire        wr_n,
    input wire [4:0]  addr,
    input wire        data_oe_n,
    input wire        busy,
    // Port and dispatch
    input wire [31:0] port_dir,
    input wire [31:0] port_out_bits,
    input wire [3:0]  cmd_strobe,
    input wire [7:0]  cmd_code_out
);
    reg  [3:0] since_wr_reg;
    wire       cmd_loc = bus_mode ? (addr[2:1] == 2'h0) : (addr[2:0] == 3'h0);

    // Cycles since the host write strobe was last active
    always @(posedge ref_clk or negedge rst_n)
        if (!rst_n)
            since_wr_reg <= 4'hf;
        else if (!cs_n && !wr_n)
            since_wr_reg <= 4'h0;
        else if (since_wr_reg != 4'hf)
            since_wr_reg <= since_wr_reg + 4'h1;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_strobe_pulse: assert property (|cmd_strobe |=> cmd_strobe == 4'h0)
        else $error("command strobe longer than one cycle");
    chk_strobe_cause: assert property (|cmd_strobe |-> since_wr_reg >= 4'h2 && since_wr_reg <= 4'h7)
        else $error("command strobe without a write");
    chk_cmd_issued: assert property ((!cs_n && !wr_n && cmd_loc) ##1 wr_n |-> ##[1:8] |cmd_strobe)
        else $error("command write gave no strobe");
    chk_invalid_quiet: assert property ((!cs_n && !wr_n && !bus_mode && addr[2:0] == 3'h3) ##1 wr_n
        |-> (cmd_strobe == 4'h0 && $stable(port_out_bits))[*8])
        else $error("invalid location write had an effect");
    chk_port_masked: assert property (((port_out_bits ^ $past(port_out_bits)) & ~port_dir & ~$past(port_dir)) == 32'h0)
        else $error("input-configured port bit changed");
    chk_oe_cause: assert property (!data_oe_n |-> $past(!cs_n && !rd_n, 3))
        else $error("bus driven without a read");
    chk_oe_on_read: assert property ((!cs_n && !rd_n)[*4] |-> !data_oe_n)
        else $error("read not answered");
    chk_busy_bound: assert property ($rose(busy) |-> ##[1:9] !busy)
        else $error("transfer busy too long");
    chk_code_hold: assert property (!$stable(cmd_code_out) |-> |cmd_strobe)
        else $error("command code changed without strobe");
    chk_soft_reset: assert property (|cmd_strobe && cmd_code_out == `CMD_SOFT_RESET |-> cmd_strobe == 4'hf)
        else $error("soft reset not sent to all axes");

    cov_busy: cover property ($rose(busy));
    cov_multi: cover property (cmd_strobe == 4'h5);
    cov_soft: cover property (cmd_strobe == 4'hf);
endmodule

bind axis_cpu_port axis_cpu_port_checker chk (.ref_clk, .rst_n, .bus_mode, .cs_n, .rd_n, .wr_n, .addr,
    .data_oe_n, .busy, .port_dir, .port_out_bits, .cmd_strobe, .cmd_code_out);

// File: host_bus_model.sv
`timescale 1ns/10ps
module host_bus_model (
    // Clock
    input wire        ref_clk,
    // Host bus
    output reg        cs_n,
    output reg        rd_n,
    output reg        wr_n,
    output reg [4:0]  addr,
    output reg [15:0] data_in,
    input wire [15:0] data_out,
    input wire        data_oe_n
);
    initial begin
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        addr <= 5'h00;
        data_in <= 16'h0000;
    end

    // Whole-unit write, strobe held 4 cycles, then a 4-cycle gap
    task wr(input [4:0] a, input [15:0] d);
        begin
            cs_n <= 1'b0;
            wr_n <= 1'b0;
            addr <= a;
            data_in <= d;
            repeat (4) @(posedge ref_clk);
            cs_n <= 1'b1;
            wr_n <= 1'b1;
            data_in <= ~d;
            repeat (4) @(posedge ref_clk);
        end
    endtask

    // Read held until the bus is driven; unknown result on timeout
    task rd(input [4:0] a, output [15:0] d);
        integer i;
        begin
            d = 16'hxxxx;
            cs_n <= 1'b0;
            rd_n <= 1'b0;
            addr <= a;
            i = 0;
            while (data_oe_n !== 1'b0 && i < 10) begin
                @(posedge ref_clk);
                i = i + 1;
            end
            if (i < 10)
                d = data_out;
            cs_n <= 1'b1;
            rd_n <= 1'b1;
            repeat (4) @(posedge ref_clk);
        end
    endtask
endmodule

// File: tb_axis_cpu_port.sv
`timescale 1ns/10ps
`include "axis_port_defs.vh"
module tb_axis_cpu_port;
    reg         ref_clk;
    reg         rst_n;
    reg         bus_mode;
    reg  [63:0] main_status;
    reg  [31:0] sub_status;
    reg  [31:0] port_dir;
    reg  [31:0] gp_term;
    wire        cs_n, rd_n, wr_n, data_oe_n, busy;
    wire [4:0]  addr;
    wire [15:0] data_in, data_out;
    wire [31:0] port_out_bits;
    wire [3:0]  cmd_strobe;
    wire [7:0]  cmd_code_out;
    integer     n_fail, samples_checked, a, i;
    reg  [3:0]  seen_sel, s;
    reg  [7:0]  seen_code, b;
    reg  [31:0] bufm [0:3];
    reg  [31:0] v, exp_port;
    reg  [15:0] d;
    reg  [5:0]  r;

    axis_cpu_port uut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_mode(bus_mode), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
        .busy(busy), .main_status(main_status), .sub_status(sub_status), .port_dir(port_dir),
        .general_purpose_terminals(gp_term), .port_out_bits(port_out_bits), .cmd_strobe(cmd_strobe),
        .cmd_code_out(cmd_code_out));
    host_bus_model host (.ref_clk(ref_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Records the last dispatched command
    always @(posedge ref_clk)
        if (cmd_strobe !== 4'h0) begin
            seen_sel <= cmd_strobe;
            seen_code <= cmd_code_out;
        end else if (!wr_n)
            seen_sel <= 4'h0;

    task check(input string name, input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("[ERR] %s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_fail);
            if (n_fail == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    task rd(input [4:0] ad, output [15:0] q);
        begin
            host.rd(ad, q);
            if (^q === 1'bx) begin
                n_fail = n_fail + 1;
                stop_test;
            end
        end
    endtask

    // Write, then wait out dispatch and any transfer
    task cmd(input [4:0] ad, input [15:0] w);
        integer k;
        begin
            host.wr(ad, w);
            repeat (4) @(posedge ref_clk);
            k = 0;
            while (busy !== 1'b0 && k < 20) begin
                @(posedge ref_clk);
                k = k + 1;
            end
            if (k == 20) begin
                n_fail = n_fail + 1;
                stop_test;
            end
        end
    endtask

    initial begin
        rst_n <= 1'b0;
        bus_mode <= `MODE_BUS8;
        main_status <= 64'h0;
        sub_status <= 32'h0;
        port_dir <= 32'h0;
        gp_term <= 32'h0;
        n_fail = 0;
        samples_checked = 0;
        i = $urandom(4);
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        main_status <= {$urandom, $urandom};
        sub_status <= $urandom;
        gp_term <= $urandom;
        port_dir <= $urandom;
        repeat (4) @(posedge ref_clk);
        // Status and port reads on every axis
        for (a = 0; a < 4; a = a + 1) begin
            rd({a[1:0], 3'h0}, d);
            check("main low", d, {8'h0, main_status[16*a +: 8]});
            rd({a[1:0], 3'h1}, d);
            check("main high", d, {8'h0, main_status[16*a+8 +: 8]});
            rd({a[1:0], 3'h2}, d);
            check("port in", d, {8'h0, gp_term[8*a +: 8]});
            rd({a[1:0], 3'h3}, d);
            check("sub status", d, {8'h0, sub_status[8*a +: 8]});
        end
        // Buffer bytes written high to low, read low to high
        for (a = 0; a < 4; a = a + 1) begin
            bufm[a] = $urandom;
            for (i = 3; i >= 0; i = i - 1)
                host.wr({a[1:0], 1'b1, i[1:0]}, {8'h0, bufm[a][8*i +: 8]});
        end
        cmd(5'h03, 16'h00a5);
        check("invalid strobe", seen_sel, 4'h0);
        for (a = 0; a < 4; a = a + 1)
            for (i = 0; i < 4; i = i + 1) begin
                rd({a[1:0], 1'b1, i[1:0]}, d);
                check("buffer byte", d, {8'h0, bufm[a][8*i +: 8]});
            end
        // Output port writes under a random direction mask
        exp_port = 32'h0;
        for (a = 0; a < 4; a = a + 1) begin
            b = $urandom;
            cmd({a[1:0], 3'h2}, {8'h0, b});
            exp_port[8*a +: 8] = (exp_port[8*a +: 8] & ~port_dir[8*a +: 8]) | (b & port_dir[8*a +: 8]);
        end
        check("port out", port_out_bits, exp_port);
        // Command dispatch, zero and random selects
        for (i = 0; i < 12; i = i + 1) begin
            a = (i < 4) ? i : $urandom % 4;
            s = (i < 4) ? 4'h0 : $urandom;
            b = 8'h50 + i;
            cmd(5'h01, {12'h0, s});
            cmd({a[1:0], 3'h0}, {8'h0, b});
            check("strobe axes", seen_sel, (s == 4'h0) ? (4'h1 << a[1:0]) : s);
            check("strobe code", seen_code, b);
        end
        cmd(5'h01, 16'h0002);
        cmd(5'h08, {8'h0, `CMD_SOFT_RESET});
        check("soft reset", seen_sel, 4'hf);
        // Second reset, then word mode
        rst_n <= 1'b0;
        bus_mode <= `MODE_BUS16;
        repeat (6) @(posedge ref_clk);
        check("reset port", port_out_bits, 32'h0);
        check("reset code", cmd_code_out, 8'h00);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        b = $urandom;
        cmd(5'h02, {~b, b});
        check("port word", port_out_bits[7:0], b & port_dir[7:0]);
        rd(5'h00, d);
        check("main word", d, main_status[15:0]);
        rd(5'h1a, d);
        check("status word", d, {sub_status[31:24], gp_term[31:24]});
        // Host fills buffers, then register write on X and Z
        r = $urandom;
        for (a = 0; a < 4; a = a + 1) begin
            bufm[a] = $urandom;
            host.wr({a[1:0], 3'h6}, bufm[a][31:16]);
            host.wr({a[1:0], 3'h4}, bufm[a][15:0]);
        end
        cmd(5'h18, {8'h05, 2'h2, r});
        for (a = 0; a < 4; a = a + 1) begin
            host.wr({a[1:0], 3'h6}, ~bufm[a][31:16]);
            host.wr({a[1:0], 3'h4}, ~bufm[a][15:0]);
        end
        cmd(5'h00, {8'h05, 2'h3, r});
        check("multi strobe", seen_sel, 4'h5);
        for (a = 0; a < 4; a = a + 1) begin
            rd({a[1:0], 3'h4}, d);
            v[15:0] = d;
            rd({a[1:0], 3'h6}, d);
            v[31:16] = d;
            check("register copy", v, a[0] ? ~bufm[a] : bufm[a]);
        end
        stop_test;
    end
endmodule
